// ===== common/csf_pkg.sv
package csf_pkg;

    // Flag positions inside the 8-bit flag register.
    localparam int FLAG_W       = 8;
    localparam int BIT_CARRY    = 0;
    localparam int BIT_HALF     = 1;
    localparam int BIT_ZERO     = 2;
    localparam int BIT_WRAP     = 3;
    localparam int BIT_PDOWN    = 4;
    localparam int BIT_WDOG     = 5;
    localparam int BIT_CHAIN    = 6;
    localparam int BIT_SIGN     = 7;
    localparam int NIBBLE_W     = 4;

    // Register map, byte addresses on the APB slave.
    localparam logic [11:0] ADDR_FLAGS  = 12'h000;
    localparam logic [11:0] ADDR_ALU_OP = 12'h004;
    localparam logic [11:0] ADDR_ALU_A  = 12'h008;
    localparam logic [11:0] ADDR_ALU_B  = 12'h00c;
    localparam logic [11:0] ADDR_RESULT = 12'h010;
    localparam logic [11:0] ADDR_EVENT  = 12'h014;

    // Event register bits: watchdog time-out, refresh and halt strobes.
    localparam int EV_TIMEOUT = 0;
    localparam int EV_REFRESH = 1;
    localparam int EV_HALT    = 2;

    // Reset value of the arithmetic flags (unknown in silicon, zero here).
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [2:0] OPCODE_ZERO = 3'h0;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;

    // Operations the flag logic understands.
    typedef enum logic [2:0] {
        CSF_OP_ADD,
        CSF_OP_ADC,
        CSF_OP_SUB,
        CSF_OP_SBC,
        CSF_OP_LOGIC,
        CSF_OP_RLC,
        CSF_OP_RRC,
        CSF_OP_NONE
    } csf_op_t;

    // One ALU request from the execution unit.
    typedef struct packed {
        logic       valid;
        csf_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
    } csf_alu_req_t;

    // Flags produced by one operation.
    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       half;
        logic       zero;
        logic       wrap;
        logic       sign;
        logic       upd_arith;
        logic       upd_carry;
        logic       chain_copy;
        logic       chain_and;
    } csf_alu_out_t;

    // System events from the watchdog and sleep logic.
    typedef struct packed {
        logic timeout;
        logic refresh;
        logic halt;
    } csf_sys_ev_t;

endpackage

// ===== hdl/csf_alu.sv
`timescale 1ns/1ps
// Combinational ALU and flag generator.
module csf_alu (
    input  csf_pkg::csf_alu_req_t req,
    input  wire logic             carry_in,
    output csf_pkg::csf_alu_out_t out
);
    import csf_pkg::*;

    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] bop;
    logic       cin;
    logic       c7;

    // Subtraction is addition of the inverted operand, so the carry out
    // is directly the not-borrow that the flags want.
    always_comb begin
        out = '0;
        bop = req.b;
        cin = 1'b0;
        case (req.op)
            CSF_OP_ADC: cin = carry_in;
            CSF_OP_SUB: begin
                bop = ~req.b;
                cin = 1'b1;
            end
            CSF_OP_SBC: begin
                bop = ~req.b;
                cin = carry_in;
            end
            default: cin = 1'b0;
        endcase
        sum = {1'b0, req.a} + {1'b0, bop} + {8'h00, cin};
        low = {1'b0, req.a[NIBBLE_W-1:0]} + {1'b0, bop[NIBBLE_W-1:0]}
            + {4'h0, cin};
        c7  = req.a[FLAG_W-1] ^ bop[FLAG_W-1] ^ sum[FLAG_W-1];
        case (req.op)
            CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC: begin
                out.result    = sum[FLAG_W-1:0];
                out.carry     = sum[FLAG_W];
                out.half      = low[NIBBLE_W];
                out.wrap      = c7 ^ sum[FLAG_W];
                out.upd_arith = 1'b1;
                out.upd_carry = 1'b1;
            end
            CSF_OP_LOGIC: begin
                out.result    = req.a & req.b;
                out.upd_arith = 1'b1;
            end
            CSF_OP_RLC: begin
                out.result    = {req.a[FLAG_W-2:0], carry_in};
                out.carry     = req.a[FLAG_W-1];
                out.upd_carry = 1'b1;
            end
            CSF_OP_RRC: begin
                out.result    = {carry_in, req.a[FLAG_W-1:1]};
                out.carry     = req.a[0];
                out.upd_carry = 1'b1;
            end
            default: out.result = BYTE_ZERO;
        endcase
        out.zero       = (out.result == BYTE_ZERO);
        out.sign       = out.wrap ^ out.result[FLAG_W-1];
        out.chain_copy = (req.op == CSF_OP_SUB);
        out.chain_and  = (req.op == CSF_OP_SBC);
    end

endmodule

// ===== hdl/csf_flag_reg.sv
`timescale 1ns/1ps
// Notes on behaviour
// - 8-bit register: sign, chain, wdog, pdown, wrap, zero, half, carry.
// - Writes update arithmetic flags; watchdog and pdown stay read-only.
// - Watchdog flag cleared by power-up, refresh or halt; set by time-out.
// - Power-down flag cleared by power-up or refresh, set by halt.
// - Carry set on addition carry out or subtraction without borrow.
// - Rotate-through-carry instructions also update the carry flag.
// - Half carry set on low-nibble carry or no nibble borrow.
// - Zero flag set when an add, subtract or logic result is zero; rotates leave it unchanged.
// - Wrap flag is carry into MSB XOR carry out of MSB.
// - Sign-compare flag is wrap flag XOR result MSB.
// - Plain subtract copies the zero flag into the chained-zero flag.
// - Borrow subtract ANDs previous chained-zero with the current zero.
// - Every other operation leaves the chained-zero flag unchanged.
// - Interrupts and calls never push the flag register automatically.
module csf_flag_reg (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  csf_pkg::csf_alu_req_t        alu_req,
    input  csf_pkg::csf_sys_ev_t         sys_ev,
    output logic      [7:0]              alu_result,
    output logic      [7:0]              flags
);
    import csf_pkg::*;

    typedef struct packed {
        logic [7:0] arith;
        logic [2:0] sw_op;
        logic [7:0] sw_a;
        logic [7:0] sw_b;
        logic [7:0] result;
        logic [31:0] rdata;
        logic        err;
    } csf_state_t;

    csf_state_t   state;
    csf_state_t   next_state;
    csf_alu_req_t req;
    csf_alu_out_t aout;
    csf_sys_ev_t  ev;
    logic         wdog;
    logic         pdown;
    logic         acc;
    logic         wr;
    logic         sw_go;
    logic         mapped;
    logic [7:0]   full;

    // APB accesses complete in the access cycle, no wait states.
    assign acc    = psel && penable;
    assign wr     = acc && pwrite;
    assign mapped = (paddr == ADDR_FLAGS) || (paddr == ADDR_ALU_OP)
                 || (paddr == ADDR_ALU_A) || (paddr == ADDR_ALU_B)
                 || (paddr == ADDR_RESULT) || (paddr == ADDR_EVENT);

    // Software may launch one ALU operation by writing the opcode register;
    // the execution unit's own request has priority when both arrive.
    assign sw_go = wr && (paddr == ADDR_ALU_OP) && !alu_req.valid;

    always_comb begin
        req = alu_req;
        if (sw_go) begin
            req.valid = 1'b1;
            req.op    = csf_op_t'(pwdata[2:0]);
            req.a     = state.sw_a;
            req.b     = state.sw_b;
        end
    end

    csf_alu u_alu (
        .req      (req),
        .carry_in (state.arith[BIT_CARRY]),
        .out      (aout)
    );

    // Software can also raise system events through the event register.
    always_comb begin
        ev = sys_ev;
        if (wr && (paddr == ADDR_EVENT)) begin
            ev.timeout = sys_ev.timeout | pwdata[EV_TIMEOUT];
            ev.refresh = sys_ev.refresh | pwdata[EV_REFRESH];
            ev.halt    = sys_ev.halt    | pwdata[EV_HALT];
        end
    end

    csf_sys_flags u_sys (
        .pclk                  (pclk),
        .presetn               (presetn),
        .ev                    (ev),
        .watchdog_expired_flag (wdog),
        .powerdown_flag        (pdown)
    );

    // Full register view; the system bits come from their own keeper.
    always_comb begin
        full            = state.arith;
        full[BIT_WDOG]  = wdog;
        full[BIT_PDOWN] = pdown;
    end

    // Flag update: an ALU operation in the same cycle as a software write
    // wins, because it is the later event in instruction order.
    always_comb begin
        next_state     = state;
        next_state.err = 1'b0;
        if (wr && (paddr == ADDR_FLAGS)) begin
            next_state.arith = pwdata[7:0];
        end
        if (wr && (paddr == ADDR_ALU_OP)) begin
            next_state.sw_op = pwdata[2:0];
        end
        if (wr && (paddr == ADDR_ALU_A)) begin
            next_state.sw_a = pwdata[7:0];
        end
        if (wr && (paddr == ADDR_ALU_B)) begin
            next_state.sw_b = pwdata[7:0];
        end
        if (req.valid) begin
            next_state.result = aout.result;
            if (aout.upd_carry) begin
                next_state.arith[BIT_CARRY] = aout.carry;
            end
            if (aout.upd_arith) begin
                next_state.arith[BIT_ZERO] = aout.zero;
                next_state.arith[BIT_HALF] = aout.half;
                next_state.arith[BIT_WRAP] = aout.wrap;
                next_state.arith[BIT_SIGN] = aout.sign;
            end
            if (aout.chain_copy) begin
                next_state.arith[BIT_CHAIN] = aout.zero;
            end else if (aout.chain_and) begin
                next_state.arith[BIT_CHAIN] =
                    state.arith[BIT_CHAIN] & aout.zero;
            end
            // Other operations keep the chained-zero bit.
        end
        // The stored copy never holds the system bits.
        next_state.arith[BIT_WDOG]  = 1'b0;
        next_state.arith[BIT_PDOWN] = 1'b0;
        // Read data is captured at the setup cycle so it is registered.
        if (psel && !penable && !pwrite) begin
            next_state.rdata = '0;
            case (paddr)
                ADDR_FLAGS:  next_state.rdata[7:0] = full;
                ADDR_ALU_OP: next_state.rdata[2:0] = state.sw_op;
                ADDR_ALU_A:  next_state.rdata[7:0] = state.sw_a;
                ADDR_ALU_B:  next_state.rdata[7:0] = state.sw_b;
                ADDR_RESULT: next_state.rdata[7:0] = state.result;
                default:     next_state.rdata = '0;
            endcase
        end
        if (psel && !penable) begin
            next_state.err = !mapped;
        end
    end

    // No stack port exists: saving flags on calls is software's job.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= '0;
            state.arith <= FLAGS_RESET;
            state.sw_op <= OPCODE_ZERO;
        end else begin
            state <= next_state;
        end
    end

    assign prdata     = state.rdata;
    assign pready     = 1'b1;
    assign pslverr    = acc && state.err;
    assign alu_result = state.result;
    assign flags      = full;

endmodule

// ===== hdl/csf_sys_flags.sv
`timescale 1ns/1ps
// Watchdog-expired and power-down flags; only system events touch them.
module csf_sys_flags (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  csf_pkg::csf_sys_ev_t ev,
    output logic               watchdog_expired_flag,
    output logic               powerdown_flag
);
    import csf_pkg::*;

    typedef struct packed {
        logic wdog;
        logic pdown;
    } csf_sys_state_t;

    csf_sys_state_t state;
    csf_sys_state_t next_state;

    // A time-out in the same cycle as a refresh wins, so it is never lost.
    always_comb begin
        next_state = state;
        if (ev.refresh || ev.halt) begin
            next_state.wdog = 1'b0;
        end
        if (ev.timeout) begin
            next_state.wdog = 1'b1;
        end
        if (ev.refresh) begin
            next_state.pdown = 1'b0;
        end
        if (ev.halt) begin
            next_state.pdown = 1'b1;
        end
    end

    // Power-on reset clears both flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign watchdog_expired_flag = state.wdog;
    assign powerdown_flag        = state.pdown;

endmodule

// ===== test/csf_exec_model.sv
`timescale 1ns/1ps
// Execution unit stand-in: issues one-cycle ALU requests and system events.
module csf_exec_model
    import csf_pkg::*;
(
    input wire logic              pclk,
    output csf_pkg::csf_alu_req_t alu_req,
    output csf_pkg::csf_sys_ev_t  sys_ev
);
    // Idle at time zero so the block sees no stray operation.
    initial begin
        alu_req = '0;
        sys_ev = '0;
    end

    // One operation; returns at the edge that takes it.
    task automatic run(input csf_op_t op, input logic [7:0] a, b);
        @(posedge pclk);
        alu_req <= '{1'b1, op, a, b};
        @(posedge pclk);
        alu_req.valid <= 1'b0;
    endtask

    // One event pulse; returns at the edge that takes it.
    task automatic pulse(input csf_sys_ev_t e);
        @(posedge pclk);
        sys_ev <= e;
        @(posedge pclk);
        sys_ev <= '0;
    endtask
endmodule

// ===== test/csf_flag_props.sv
`timescale 1ns/1ps
// Watches the flag register ports; every flag rule ties an output to its cause.
module csf_flag_props
    import csf_pkg::*;
(
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input csf_pkg::csf_alu_req_t alu_req,
    input csf_pkg::csf_sys_ev_t  sys_ev,
    input wire logic [7:0]       alu_result,
    input wire logic [7:0]       flags
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // System flags only move on a system event or an event register write.
    wire quiet = !sys_ev.timeout && !sys_ev.refresh && !sys_ev.halt &&
                 !(psel && pwrite && paddr == ADDR_EVENT);
    wire go = alu_req.valid;

    AST_WD_SET: assert property (sys_ev.timeout |=> flags[BIT_WDOG])
        else $error("watchdog flag not set by time-out");
    AST_WD_CLR: assert property ((sys_ev.refresh || sys_ev.halt) &&
        !sys_ev.timeout |=> !flags[BIT_WDOG])
        else $error("watchdog flag not cleared");
    AST_PD_SET: assert property (sys_ev.halt |=> flags[BIT_PDOWN])
        else $error("power-down flag not set by halt");
    AST_PD_CLR: assert property (sys_ev.refresh && !sys_ev.halt
        |=> !flags[BIT_PDOWN])
        else $error("power-down flag not cleared by refresh");
    AST_SYS_HOLD: assert property (quiet |=> $stable(flags[5:4]))
        else $error("system flags moved without an event");
    AST_ADD_SUM: assert property (go && alu_req.op == CSF_OP_ADD
        |=> {flags[BIT_CARRY], alu_result} ==
            {1'b0, $past(alu_req.a)} + {1'b0, $past(alu_req.b)})
        else $error("addition carry or sum wrong");
    AST_SIGN: assert property (go && alu_req.op inside {CSF_OP_ADD,
        CSF_OP_SUB, CSF_OP_SBC}
        |=> flags[BIT_SIGN] == (flags[BIT_WRAP] ^ alu_result[7]))
        else $error("sign-compare flag wrong");
    AST_CHAIN_SUB: assert property (go && alu_req.op == CSF_OP_SUB
        |=> flags[BIT_CHAIN] == flags[BIT_ZERO])
        else $error("chained zero differs from zero after subtract");
    AST_CHAIN_SBC: assert property (go && alu_req.op == CSF_OP_SBC
        |=> flags[BIT_CHAIN] ==
            ($past(flags[BIT_CHAIN]) && flags[BIT_ZERO]))
        else $error("chained zero not accumulated");
    AST_CHAIN_HOLD: assert property (go && alu_req.op inside
        {CSF_OP_ADD, CSF_OP_LOGIC, CSF_OP_RLC, CSF_OP_RRC}
        |=> $stable(flags[BIT_CHAIN]))
        else $error("chained zero changed by other operation");

    COV_SBC: cover property (go && alu_req.op == CSF_OP_SBC);
    COV_HALT: cover property (sys_ev.halt);
    COV_ROT: cover property (go && alu_req.op == CSF_OP_RLC);
endmodule

bind csf_flag_reg csf_flag_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .pwrite(pwrite), .paddr(paddr), .alu_req(alu_req),
    .sys_ev(sys_ev), .alu_result(alu_result), .flags(flags));

// ===== test/tb_cpu_status_flag_register.sv
`timescale 1ns/1ps
// Self-checking bench for the flag register block.
module tb_cpu_status_flag_register;
    import csf_pkg::*;
    typedef struct packed {
        csf_op_t    op;
        logic [7:0] a, b, res, f;
    } csf_vec_t;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [7:0]   alu_result, flags;
    csf_alu_req_t alu_req;
    csf_sys_ev_t  sys_ev;
    csf_vec_t     vec [14];
    int           bad_count, check_count;

    csf_flag_reg dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .alu_req(alu_req), .sys_ev(sys_ev), .alu_result(alu_result),
        .flags(flags));
    csf_exec_model u_exe (.pclk(pclk), .alu_req(alu_req), .sys_ev(sys_ev));

    // Free-running 50 ns clock.
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; the wait for pready is bounded so a hang ends the run.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t pready never came", $time);
            summarize();
        end
    endtask

    // Arithmetic sequence: carries, borrows, chained zero and rotates.
    task automatic t_alu();
        vec = '{'{CSF_OP_ADD, 8'hff, 8'h01, 8'h00, 8'h07},
                '{CSF_OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h0a},
                '{CSF_OP_SUB, 8'h05, 8'h05, 8'h00, 8'h47},
                '{CSF_OP_SBC, 8'h07, 8'h07, 8'h00, 8'h47},
                '{CSF_OP_RRC, 8'h02, 8'h00, 8'h81, 8'h46},
                '{CSF_OP_SBC, 8'h07, 8'h06, 8'h00, 8'h47},
                '{CSF_OP_SBC, 8'h07, 8'h06, 8'h01, 8'h03},
                '{CSF_OP_SBC, 8'h00, 8'h00, 8'h00, 8'h07},
                '{CSF_OP_SUB, 8'h03, 8'h05, 8'hfe, 8'h80},
                '{CSF_OP_RLC, 8'h80, 8'h00, 8'h00, 8'h81},
                '{CSF_OP_ADD, 8'h10, 8'h20, 8'h30, 8'h00},
                '{CSF_OP_RLC, 8'h81, 8'h00, 8'h02, 8'h01},
                '{CSF_OP_ADC, 8'h0f, 8'h00, 8'h10, 8'h02},
                '{CSF_OP_LOGIC, 8'hff, 8'h00, 8'h00, 8'h04}};
        foreach (vec[i]) begin
            u_exe.run(vec[i].op, vec[i].a, vec[i].b);
            #1;
            chk({24'h0, alu_result}, {24'h0, vec[i].res}, "result");
            chk({24'h0, flags}, {24'h0, vec[i].f}, "flags");
            chk(flags[0], vec[i].f[0], "carry");
            chk(flags[1], vec[i].f[1], "half");
            chk(flags[3:2], vec[i].f[3:2], "zero wrap");
            chk(flags[7], vec[i].f[7], "sign");
            chk(flags[6], vec[i].f[6], "chain");
        end
    endtask

    // System flags against events and software writes.
    task automatic t_sys();
        apb(1'b1, ADDR_EVENT, 32'h1);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd, 32'h24, "timeout");
        apb(1'b1, ADDR_FLAGS, 32'h0);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd, 32'h20, "write 00");
        u_exe.pulse(3'b001);
        #1;
        chk({24'h0, flags}, 32'h10, "halt");
        apb(1'b1, ADDR_FLAGS, 32'hff);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd, 32'hdf, "write ff");
        u_exe.pulse(3'b010);
        #1;
        chk({24'h0, flags}, 32'hcf, "refresh");
        apb(1'b0, 12'h0f0, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped");
        chk(rd, 32'h0, "unmapped read");
    endtask

    // Software operands, a software-launched subtract and event strobes.
    task automatic t_sw();
        apb(1'b1, ADDR_ALU_A, 32'h34);
        apb(1'b1, ADDR_ALU_B, 32'h12);
        apb(1'b1, ADDR_ALU_OP, 32'h2);
        apb(1'b0, ADDR_RESULT, 32'h0);
        chk(rd, 32'h22, "sw result");
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd, 32'h03, "sw flags");
        chk({31'h0, er}, 32'h0, "mapped");
        apb(1'b0, ADDR_ALU_OP, 32'h0);
        chk(rd, 32'h2, "opcode");
        apb(1'b0, ADDR_ALU_B, 32'h0);
        chk(rd, 32'h12, "operand b");
        apb(1'b1, ADDR_EVENT, 32'h4);
        apb(1'b0, ADDR_EVENT, 32'h0);
        chk(rd, 32'h0, "event read");
        chk({24'h0, flags}, 32'h13, "sw halt");
        apb(1'b1, ADDR_EVENT, 32'h2);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd, 32'h03, "sw refresh");
    endtask

    // A reset in mid-run must clear the system flags again.
    task automatic t_rst();
        u_exe.pulse(3'b100);
        #1;
        chk({24'h0, flags}, 32'h23, "timeout again");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk({24'h0, flags}, {24'h0, FLAGS_RESET}, "reset again");
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk({30'h0, flags[5:4]}, 32'h0, "reset");
        t_alu();
        t_sys();
        t_sw();
        t_rst();
        summarize();
    end
endmodule
